/* verilog/ccs_map.svh */
// Register map, field positions, reset values and pattern memory widths for the
// clock sequencer. Assumes 32-bit APB with one register per aligned word.
`ifndef CCS_MAP_SVH
`define CCS_MAP_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CCS_CTRL_OFS 8'h00
`define CCS_LINE_LEN_OFS 8'h04
`define CCS_ROWS_OFS 8'h08
`define CCS_WIN_OFS 8'h0C
`define CCS_DIV_OFS 8'h10
`define CCS_STATUS_OFS 8'h14
`define CCS_COUNT_OFS 8'h18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CCS_CTRL_LOGIC_EN 0
`define CCS_WIN_HI_LSB 16

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CCS_CTRL_RST 32'h0000_0000
`define CCS_LINE_LEN_RST 12'h100
`define CCS_ROWS_RST 12'h100
`define CCS_WIN_LO_RST 12'h000
`define CCS_WIN_HI_RST 12'h0FF
`define CCS_DIV_RST 8'h03

// ----------------------------------------
// Pattern memory layout
// ----------------------------------------
`define CCS_ADDR_W 8
`define CCS_STEP_W 6
`define CCS_PAT_W 16

`endif

/* verilog/ccs_pkg.sv */
// Types shared by the clock sequencer: sequencer states, operation
// regions of the pattern memory and the pattern word layout.
package ccs_pkg;

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  typedef enum logic [2:0] {
    CCS_IDLE = 3'b000,
    CCS_LXFER = 3'b001,
    CCS_IXFER = 3'b010,
    CCS_LREAD = 3'b011,
    CCS_PREAD = 3'b100
  } ccs_state_t;

  // Pattern memory region, upper two address bits
  typedef enum logic [1:0] {
    CCS_REG_LXFER = 2'b00,
    CCS_REG_IXFER = 2'b01,
    CCS_REG_PIXEL = 2'b10,
    CCS_REG_SPARE = 2'b11
  } ccs_region_t;

  // ----------------------------------------
  // Pattern word, high level = strobe active
  // ----------------------------------------
  typedef struct packed {
    logic seq_end;
    logic clamp;
    logic sample;
    logic suppress;
    logic convert;
    logic [2:0] horiz;
    logic reset_pulse;
    logic [2:0] image;
    logic [2:0] store;
    logic spare;
  } ccs_pat_t;

endpackage

/* verilog/ccs_clock_sequencer.sv */
// CCD clock sequencer: walks an external pattern memory to produce the
// image, storage and horizontal phase clocks and the sample/convert strobes.
// Assumes the pattern memory answers within one camera clock tick and that
// command inputs are synchronous to mclk.
`timescale 1ns/10ps
`include "ccs_map.svh"
`default_nettype none

module ccs_clock_sequencer
  import ccs_pkg::*;
#(
  parameter int CW = 12,
  parameter int DW = 8
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic line_xfer_cmd,
  input wire logic image_xfer_cmd,
  input wire logic line_read_cmd,
  input wire logic pixel_read_cmd,
  input wire logic converter_enable,
  input wire logic output_select,
  input wire logic [`CCS_PAT_W-1:0] pattern_data,
  output logic pattern_mem_select_n,
  output logic [`CCS_ADDR_W-1:0] pattern_addr,
  output logic cam_clk,
  output logic horiz_clk_en_n,
  output logic image_clk_en_n,
  output logic image_clk_en,
  output logic store_clk_en_n,
  output logic store_clk_en,
  output logic black_clamp_n,
  output logic intensity_sample_n,
  output logic input_suppress_n,
  output logic conv_start_n,
  output logic [2:0] horiz_phase,
  output logic output_reset_pulse,
  output logic [2:0] image_phase,
  output logic [2:0] store_phase,
  output logic busy,
  output logic digitise_window,
  output logic pixel_end_n,
  output logic data_mode,
  output logic logic_enable_n
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  generate
    if (CW < 12 || CW > 16)
    begin : g_cw_bad
      $error("CW must be 12 to 16");
    end
    if (DW < 2 || DW > 16)
    begin : g_dw_bad
      $error("DW must be 2 to 16");
    end
  endgenerate

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic ctrl_en_q;
  logic [CW-1:0] line_len_q;
  logic [CW-1:0] rows_q;
  logic [CW-1:0] win_lo_q;
  logic [CW-1:0] win_hi_q;
  logic [DW-1:0] div_q;
  logic [DW-1:0] div_cnt_q;
  logic tick;
  ccs_state_t state_q;
  logic primed_q;
  logic [`CCS_STEP_W-1:0] step_q;
  ccs_region_t region_q;
  ccs_pat_t pat_q;
  ccs_pat_t pat_in;
  logic [CW-1:0] col_q;
  logic [CW-1:0] row_q;
  logic seq_done;
  logic multi_line_done;
  logic single_pixel_done;
  logic horiz_on;
  logic image_on;
  logic store_on;
  logic acc;
  logic wr_en;
  logic start;
  ccs_state_t start_op;
  logic [31:0] rd_word;
  logic rd_ok;

  assign pat_in = ccs_pat_t'(pattern_data);

  // ----------------------------------------
  // APB slave, one wait state
  // ----------------------------------------
  assign acc = psel && penable;
  assign wr_en = acc && pready && pwrite && rd_ok;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    case (paddr)
      `CCS_CTRL_OFS: rd_word[`CCS_CTRL_LOGIC_EN] = ctrl_en_q;
      `CCS_LINE_LEN_OFS: rd_word[CW-1:0] = line_len_q;
      `CCS_ROWS_OFS: rd_word[CW-1:0] = rows_q;
      `CCS_WIN_OFS:
      begin
        rd_word[CW-1:0] = win_lo_q;
        rd_word[`CCS_WIN_HI_LSB +: CW] = win_hi_q;
      end
      `CCS_DIV_OFS: rd_word[DW-1:0] = div_q;
      `CCS_STATUS_OFS:
      begin
        rd_word[0] = busy;
        rd_word[3:1] = state_q;
        rd_word[4] = digitise_window;
        rd_word[5] = data_mode;
      end
      `CCS_COUNT_OFS:
      begin
        rd_word[CW-1:0] = col_q;
        rd_word[16 +: CW] = row_q;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (acc && !pready)
    begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : rd_word;
      pslverr <= !rd_ok;
    end
    else
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // Writable registers; read-only offsets take no write
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ctrl_en_q <= 1'(`CCS_CTRL_RST);
      line_len_q <= CW'(`CCS_LINE_LEN_RST);
      rows_q <= CW'(`CCS_ROWS_RST);
      win_lo_q <= CW'(`CCS_WIN_LO_RST);
      win_hi_q <= CW'(`CCS_WIN_HI_RST);
      div_q <= DW'(`CCS_DIV_RST);
    end
    else if (wr_en)
    begin
      case (paddr)
        `CCS_CTRL_OFS: ctrl_en_q <= pwdata[`CCS_CTRL_LOGIC_EN];
        `CCS_LINE_LEN_OFS: line_len_q <= pwdata[CW-1:0];
        `CCS_ROWS_OFS: rows_q <= pwdata[CW-1:0];
        `CCS_WIN_OFS:
        begin
          win_lo_q <= pwdata[CW-1:0];
          win_hi_q <= pwdata[`CCS_WIN_HI_LSB +: CW];
        end
        `CCS_DIV_OFS: div_q <= pwdata[DW-1:0];
        default: ctrl_en_q <= ctrl_en_q;
      endcase
    end
  end

  // ----------------------------------------
  // Camera clock divider
  // ----------------------------------------
  // Period is 2*(div+1) mclk; the tick paces the pattern walk
  assign tick = (div_cnt_q == '0);

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      div_cnt_q <= '0;
      cam_clk <= 1'b0;
    end
    else if (tick)
    begin
      div_cnt_q <= div_q;
      cam_clk <= !cam_clk;
    end
    else
    begin
      div_cnt_q <= div_cnt_q - 1'b1;
    end
  end

  // ----------------------------------------
  // Command acceptance
  // ----------------------------------------
  // Image transfer has priority, then line transfer, line read, pixel read
  always_comb
  begin
    start_op = CCS_IDLE;
    if (image_xfer_cmd)
      start_op = CCS_IXFER;
    else if (line_xfer_cmd)
      start_op = CCS_LXFER;
    else if (line_read_cmd)
      start_op = CCS_LREAD;
    else if (pixel_read_cmd)
      start_op = CCS_PREAD;
  end

  // Commands during busy are dropped, not queued
  assign start = (state_q == CCS_IDLE) && (start_op != CCS_IDLE);

  // ----------------------------------------
  // Raster limits
  // ----------------------------------------
  // A sequence ends when the end bit arrives in a fetched word
  assign seq_done = tick && primed_q && pat_in.seq_end;
  assign single_pixel_done = seq_done;

  always_comb
  begin
    multi_line_done = 1'b0;
    case (state_q)
      CCS_LXFER: multi_line_done = seq_done;
      CCS_PREAD: multi_line_done = seq_done;
      CCS_IXFER: multi_line_done = seq_done && (row_q + 1'b1 >= rows_q);
      CCS_LREAD: multi_line_done = seq_done && (col_q + 1'b1 >= line_len_q);
      default: multi_line_done = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_q <= CCS_IDLE;
      region_q <= CCS_REG_LXFER;
      step_q <= '0;
      primed_q <= 1'b0;
    end
    else if (start)
    begin
      state_q <= start_op;
      step_q <= '0;
      primed_q <= 1'b0;
      case (start_op)
        CCS_IXFER: region_q <= CCS_REG_IXFER;
        CCS_LXFER: region_q <= CCS_REG_LXFER;
        default: region_q <= CCS_REG_PIXEL;
      endcase
    end
    else if (tick && state_q != CCS_IDLE)
    begin
      if (multi_line_done)
      begin
        state_q <= CCS_IDLE;
        step_q <= '0;
        primed_q <= 1'b0;
      end
      else if (seq_done)
      begin
        // Restart pattern; drop the first word fetched after the restart
        step_q <= '0;
        primed_q <= 1'b0;
      end
      else
      begin
        step_q <= step_q + 1'b1;
        primed_q <= 1'b1;
      end
    end
  end

  // Column follows the horizontal register; a line transfer refills it
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      col_q <= '0;
      row_q <= '0;
    end
    else if (start && start_op == CCS_LXFER)
    begin
      col_q <= '0;
    end
    else if (start && start_op == CCS_IXFER)
    begin
      row_q <= '0;
    end
    else if (seq_done)
    begin
      case (state_q)
        CCS_LREAD: col_q <= multi_line_done ? '0 : col_q + 1'b1;
        CCS_PREAD: col_q <= col_q + 1'b1;
        CCS_IXFER: row_q <= multi_line_done ? '0 : row_q + 1'b1;
        default: row_q <= row_q;
      endcase
    end
  end

  // ----------------------------------------
  // Pattern memory port
  // ----------------------------------------
  // Memory is deselected while idle to save power
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pattern_mem_select_n <= 1'b1;
      pattern_addr <= '0;
      pat_q <= '0;
    end
    else
    begin
      pattern_mem_select_n <= (state_q == CCS_IDLE) && !start;
      pattern_addr <= {region_q, step_q};
      if (state_q == CCS_IDLE)
        pat_q <= '0;
      else if (tick)
        pat_q <= primed_q ? pat_in : '0;
    end
  end

  // ----------------------------------------
  // Area enables
  // ----------------------------------------
  assign horiz_on = (state_q == CCS_LREAD) || (state_q == CCS_PREAD);
  assign image_on = (state_q == CCS_IXFER);
  assign store_on = (state_q == CCS_IXFER) || (state_q == CCS_LXFER);

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      horiz_clk_en_n <= 1'b1;
      image_clk_en_n <= 1'b1;
      image_clk_en <= 1'b0;
      store_clk_en_n <= 1'b1;
      store_clk_en <= 1'b0;
    end
    else
    begin
      horiz_clk_en_n <= !horiz_on;
      image_clk_en_n <= !image_on;
      image_clk_en <= image_on;
      store_clk_en_n <= !store_on;
      store_clk_en <= store_on;
    end
  end

  // ----------------------------------------
  // Gated clocks and strobes
  // ----------------------------------------
  // Strobes are active low; gated-off means held high
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      black_clamp_n <= 1'b1;
      intensity_sample_n <= 1'b1;
      input_suppress_n <= 1'b1;
      conv_start_n <= 1'b1;
      horiz_phase <= 3'h0;
      output_reset_pulse <= 1'b0;
      image_phase <= 3'h0;
      store_phase <= 3'h0;
    end
    else
    begin
      black_clamp_n <= !(horiz_on && pat_q.clamp);
      intensity_sample_n <= !(horiz_on && pat_q.sample);
      input_suppress_n <= !(horiz_on && pat_q.suppress);
      conv_start_n <= !(horiz_on && converter_enable && pat_q.convert);
      horiz_phase <= horiz_on ? pat_q.horiz : 3'h0;
      output_reset_pulse <= horiz_on && pat_q.reset_pulse;
      image_phase <= image_on ? pat_q.image : 3'h0;
      store_phase <= store_on ? pat_q.store : 3'h0;
    end
  end

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      busy <= 1'b0;
      pixel_end_n <= 1'b1;
      digitise_window <= 1'b0;
      data_mode <= 1'b0;
      logic_enable_n <= 1'b1;
    end
    else
    begin
      busy <= (state_q != CCS_IDLE) || start;
      pixel_end_n <= !single_pixel_done;
      digitise_window <= horiz_on && (col_q >= win_lo_q) && (col_q <= win_hi_q);
      data_mode <= output_select;
      logic_enable_n <= !ctrl_en_q;
    end
  end

endmodule

`default_nettype wire

/* verification/ccs_pattern_mem.sv */
// Behavioural pattern memory facing the sequencer's address and select.
// Assumes a one-mclk read; unselected data toggles every cycle.
`timescale 1ns/10ps
`default_nettype none
module ccs_pattern_mem
  import ccs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic select_n,
  input wire logic [7:0] addr,
  output logic [15:0] data
);
  ccs_pat_t w;
  // ----------------------------------------
  // Five steps per pattern, any region
  // ----------------------------------------
  // Step 0 stays blank: the sequencer drops the first word after a restart
  always_comb
  begin
    w = '0;
    w.clamp = addr[5:0] == 6'h01;
    w.suppress = addr[5:0] == 6'h01;
    w.reset_pulse = addr[5:0] == 6'h01;
    w.sample = addr[5:0] == 6'h02;
    w.convert = addr[5:0] == 6'h03;
    w.seq_end = addr[5:0] == 6'h04;
    w.horiz = {addr[5:0] == 6'h03, addr[5:0] == 6'h02, addr[5:0] == 6'h01};
    w.image = {addr[5:0] == 6'h03, addr[5:0] == 6'h02, addr[5:0] == 6'h01};
    w.store = {addr[5:0] == 6'h03, addr[5:0] == 6'h02, addr[5:0] == 6'h01};
  end
  // Deselected: invert the held word every cycle, so the last word returns on alternate cycles
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      data <= 16'h0;
    else
      data <= select_n ? ~data : 16'(w);
  end
endmodule
`default_nettype wire

/* verification/ccs_clock_sequencer_sva.sv */
// Port checker for the clock sequencer, bound to every instance.
// Assumes the divider register stays at its reset value.
`timescale 1ns/10ps
`default_nettype none
`include "ccs_map.svh"
module ccs_seq_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic line_xfer_cmd,
  input wire logic image_xfer_cmd,
  input wire logic line_read_cmd,
  input wire logic pixel_read_cmd,
  input wire logic output_select,
  input wire logic pattern_mem_select_n,
  input wire logic [`CCS_ADDR_W-1:0] pattern_addr,
  input wire logic cam_clk,
  input wire logic horiz_clk_en_n,
  input wire logic image_clk_en_n,
  input wire logic image_clk_en,
  input wire logic store_clk_en_n,
  input wire logic store_clk_en,
  input wire logic intensity_sample_n,
  input wire logic conv_start_n,
  input wire logic [2:0] horiz_phase,
  input wire logic [2:0] image_phase,
  input wire logic [2:0] store_phase,
  input wire logic busy,
  input wire logic digitise_window,
  input wire logic pixel_end_n,
  input wire logic data_mode,
  input wire logic logic_enable_n
);
  localparam logic [2:0] div_ticks = 3'(`CCS_DIV_RST);
  logic [2:0] cnt_q;
  logic seen_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Cycles since the camera clock last moved
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cnt_q <= 3'h0;
      seen_q <= 1'b0;
    end
    else
    begin
      cnt_q <= $changed(cam_clk) ? 3'h0 : cnt_q + 3'h1;
      seen_q <= seen_q | $changed(cam_clk);
    end
  end
  sequence idle_req;
    !busy && pattern_mem_select_n;
  endsequence
  sequence pix_req;
    idle_req ##0 pixel_read_cmd && !image_xfer_cmd && !line_xfer_cmd && !line_read_cmd;
  endsequence
  sequence img_req;
    idle_req ##0 image_xfer_cmd;
  endsequence
  sequence ctrl_wr;
    psel && penable && pready && pwrite && paddr == `CCS_CTRL_OFS;
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  mem_select_a: assert property (!pattern_mem_select_n |-> busy)
    else $error("memory selected while not busy");
  horiz_gate_a: assert property (horiz_clk_en_n |-> horiz_phase == 3'h0 && conv_start_n && intensity_sample_n)
    else $error("horizontal clocks move while disabled");
  image_gate_a: assert property ((image_clk_en == !image_clk_en_n) && (!image_clk_en_n || image_phase == 3'h0))
    else $error("image enable pair or gating wrong");
  store_gate_a: assert property ((store_clk_en == !store_clk_en_n) && (!store_clk_en_n || store_phase == 3'h0))
    else $error("storage enable pair or gating wrong");
  idle_quiet_a: assert property (!busy && !$past(busy) |-> (horiz_phase | image_phase | store_phase) == 3'h0)
    else $error("phase clock active while idle");
  end_pulse_a: assert property (!pixel_end_n |-> busy ##1 pixel_end_n)
    else $error("end of pixel pulse malformed");
  window_gate_a: assert property (digitise_window |-> !horiz_clk_en_n)
    else $error("window open without horizontal clocks");
  cam_div_a: assert property (seen_q && $changed(cam_clk) |-> cnt_q == div_ticks)
    else $error("camera clock spacing wrong");
  logic_en_a: assert property (ctrl_wr |-> ##2 logic_enable_n == !$past(pwdata[0], 2))
    else $error("logic enable does not follow control");
  mode_copy_a: assert property (1'b1 |=> data_mode == $past(output_select))
    else $error("data mode does not follow select");
  pixel_start_a: assert property (pix_req |=> ##1 busy && !pattern_mem_select_n && pattern_addr[7:6] == 2'b10)
    else $error("pixel read start wrong");
  image_start_a: assert property (img_req |=> ##1 busy && pattern_addr[7:6] == 2'b01)
    else $error("image transfer start wrong");
endmodule
bind ccs_clock_sequencer ccs_seq_chk ccs_seq_chk_i (
  .mclk, .rst_n, .psel, .penable, .pwrite, .pready, .paddr, .pwdata, .line_xfer_cmd, .image_xfer_cmd,
  .line_read_cmd, .pixel_read_cmd, .output_select, .pattern_mem_select_n, .pattern_addr, .cam_clk,
  .horiz_clk_en_n, .image_clk_en_n, .image_clk_en, .store_clk_en_n, .store_clk_en, .intensity_sample_n,
  .conv_start_n, .horiz_phase, .image_phase, .store_phase, .busy, .digitise_window, .pixel_end_n,
  .data_mode, .logic_enable_n
);
`default_nettype wire

/* verification/ccs_clock_sequencer_tb.sv */
// Self-checking bench: APB master, command pulses, pattern memory model.
// Assumes register offsets of ccs_map.svh and the default divider.
`timescale 1ns/10ps
`default_nettype none
`include "ccs_map.svh"
module ccs_clock_sequencer_tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] cmd = 4'h0;
  logic conv_en = 1'b1;
  logic out_sel = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, pattern_mem_select_n, cam_clk, horiz_clk_en_n, image_clk_en_n, image_clk_en;
  logic store_clk_en_n, store_clk_en, black_clamp_n, intensity_sample_n, input_suppress_n, conv_start_n;
  logic output_reset_pulse, busy, digitise_window, pixel_end_n, data_mode, logic_enable_n;
  logic [2:0] horiz_phase, image_phase, store_phase, sh, si, ss;
  logic [7:0] pattern_addr;
  logic [15:0] pattern_data;
  logic s_clamp, s_samp, s_supp, s_conv, s_rst, s_win, s_sel;
  int ends;
  int errors = 0;
  int compares = 0;
  initial
  begin
    forever #4 mclk = ~mclk;
  end
  ccs_clock_sequencer ccs_clock_sequencer_i (
    .mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .line_xfer_cmd(cmd[2]), .image_xfer_cmd(cmd[3]), .line_read_cmd(cmd[1]), .pixel_read_cmd(cmd[0]),
    .converter_enable(conv_en), .output_select(out_sel), .pattern_data, .pattern_mem_select_n, .pattern_addr,
    .cam_clk, .horiz_clk_en_n, .image_clk_en_n, .image_clk_en, .store_clk_en_n, .store_clk_en, .black_clamp_n,
    .intensity_sample_n, .input_suppress_n, .conv_start_n, .horiz_phase, .output_reset_pulse, .image_phase,
    .store_phase, .busy, .digitise_window, .pixel_end_n, .data_mode, .logic_enable_n
  );
  ccs_pattern_mem ccs_pattern_mem_i (
    .mclk, .rst_n, .select_n(pattern_mem_select_n), .addr(pattern_addr), .data(pattern_data)
  );
  // ----------------------------------------
  // Reporting
  // ----------------------------------------
  task automatic summarize();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic hang();
    errors++;
    $display("unexpected at %0t: wait ran out", $time);
    summarize();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
    compares++;
    if (got !== want)
    begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask
  // ----------------------------------------
  // APB master and command driver
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      hang();
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] want, input logic err);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, want, "read data");
    chk(32'(e), 32'(err), "read error");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk(32'(e), 32'h0, "write error");
  endtask
  // Pulses c, then late while busy; gathers what the outputs did
  task automatic run(input logic [3:0] c, input logic [3:0] late);
    int n;
    {sh, si, ss, s_clamp, s_samp, s_supp, s_conv, s_rst, s_win, s_sel} = '0;
    ends = 0;
    n = 0;
    @(posedge mclk);
    cmd <= c;
    do
    begin
      @(posedge mclk);
      cmd <= (n == 4) ? late : 4'h0;
      #1;
      n++;
      sh |= horiz_phase;
      si |= image_phase;
      ss |= store_phase;
      s_clamp |= !black_clamp_n;
      s_samp |= !intensity_sample_n;
      s_supp |= !input_suppress_n;
      s_conv |= !conv_start_n;
      s_rst |= output_reset_pulse;
      s_win |= digitise_window;
      s_sel |= !pattern_mem_select_n;
      ends += int'(!pixel_end_n);
    end
    while ((busy !== 1'b0 || n < 3) && n < 3000);
    if (n >= 3000)
      hang();
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    rd(`CCS_CTRL_OFS, `CCS_CTRL_RST, 1'b0);
    rd(`CCS_DIV_OFS, 32'(`CCS_DIV_RST), 1'b0);
    rd(`CCS_WIN_OFS, {4'h0, `CCS_WIN_HI_RST, 4'h0, `CCS_WIN_LO_RST}, 1'b0);
    rd(8'h1C, 32'h0, 1'b1);
    chk(32'(logic_enable_n), 32'h1, "logic enable idle");
    wr(`CCS_CTRL_OFS, 32'h1);
    repeat (2) @(posedge mclk);
    #1 chk(32'(logic_enable_n), 32'h0, "logic enable on");
    $display("test regs done");
  endtask
  task automatic t_pixel();
    run(4'b0001, 4'h0);
    chk(32'(ends), 32'h1, "pixel ends");
    chk(32'({s_clamp, s_samp, s_supp, s_conv, s_rst, s_sel}), 32'h3F, "pixel strobes");
    chk(32'({sh, si, ss}), 32'h1C0, "pixel phases");
    chk(32'(pattern_mem_select_n), 32'h1, "memory released");
    $display("test pixel done");
  endtask
  task automatic t_ignore();
    run(4'b0001, 4'b1000);
    chk(32'(ends), 32'h1, "busy ends");
    chk(32'(si), 32'h0, "busy image");
    $display("test ignore done");
  endtask
  task automatic t_xfer();
    wr(`CCS_ROWS_OFS, 32'h3);
    run(4'b0100, 4'h0);
    chk(32'({sh, si, ss, s_samp, s_conv}), 32'h1C, "line xfer");
    chk(32'(ends), 32'h1, "line xfer ends");
    run(4'b1100, 4'h0);
    chk(32'({sh, si, ss}), 32'h3F, "image xfer");
    chk(32'(ends), 32'h3, "image rows");
    $display("test xfer done");
  endtask
  task automatic t_line();
    wr(`CCS_LINE_LEN_OFS, 32'h4);
    wr(`CCS_WIN_OFS, 32'h0002_0001);
    @(posedge mclk);
    conv_en <= 1'b0;
    run(4'b0010, 4'h0);
    chk(32'(ends), 32'h4, "line pixels");
    chk(32'({s_win, s_conv, sh}), 32'h17, "line window");
    @(posedge mclk);
    conv_en <= 1'b1;
    $display("test line done");
  endtask
  task automatic t_mode();
    @(posedge mclk);
    out_sel <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk(32'(data_mode), 32'h1, "data mode");
    @(posedge mclk);
    out_sel <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk(32'(data_mode), 32'h0, "telemetry mode");
    $display("test mode done");
  endtask
  initial
  begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_pixel();
    t_ignore();
    t_xfer();
    t_line();
    t_mode();
    summarize();
  end
endmodule
`default_nettype wire
